// ### logic/bis_pkg.sv
package bis_pkg;

  // ---------------------------------------------------------------------------
  // Clock and time base
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_US = 10_000;
  localparam int TICK_CYCLES_DEF = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int KEY_HOLD_US = 1_000_000;
  localparam int KEY_HOLD_TICKS = (KEY_HOLD_US + TICK_US - 1) / TICK_US;
  localparam logic [15:0] STARTUP_TICKS = 16'h0002;

  // ---------------------------------------------------------------------------
  // Register map, per unit window of 32 bytes
  // ---------------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int UNIT_SHIFT = 5;
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_TIME0 = 5'h04;
  localparam logic [4:0] OFF_TIME1 = 5'h08;
  localparam logic [4:0] OFF_TIME2 = 5'h0C;
  localparam logic [4:0] OFF_STATUS = 5'h10;

  // Control fields.
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_PTS_BIT = 1;
  localparam int CTRL_CLEAR_BIT = 2;
  localparam logic CTRL_ENABLE_RST = 1'b1;
  localparam logic CTRL_PTS_RST = 1'b0;

  // Duration fields in ticks, and the attempt counts in TIME2.
  localparam int T0_FIRST_PURGE_LSB = 0;
  localparam int T0_IGNITION_LSB = 16;
  localparam int T1_PURGE_LSB = 0;
  localparam int T1_WAIT_LSB = 16;
  localparam int T2_ESTABLISH_LSB = 0;
  localparam int T2_IGN_ATTEMPTS_LSB = 16;
  localparam int T2_WAIT_ATTEMPTS_LSB = 24;
  localparam logic [31:0] TIME0_RST = 32'h01F4_05DC;
  localparam logic [31:0] TIME1_RST = 32'h1770_03E8;
  localparam logic [31:0] TIME2_RST = 32'h0203_012C;

  // Status fields.
  localparam int ST_STATE_LSB = 0;
  localparam int ST_ESD_BIT = 4;
  localparam int ST_PILOT_BIT = 5;
  localparam int ST_PROCESS_BIT = 6;
  localparam int ST_IGNITER_BIT = 7;
  localparam int ST_ALARM_BIT = 8;
  localparam int ST_IGN_LEFT_LSB = 16;
  localparam int ST_WAIT_LEFT_LSB = 24;

  // ---------------------------------------------------------------------------
  // Unit sequencer state
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_DISABLED,
    ST_STOPPED,
    ST_STARTUP,
    ST_FIRST_PURGE,
    ST_IGNITE,
    ST_PURGE,
    ST_WAIT,
    ST_FLAME_ESTABLISH,
    ST_PILOT_ON,
    ST_IDLE,
    ST_PROCESS_ONE_RUNNING,
    ST_PILOT_FAIL,
    ST_SHUTDOWN,
    ST_ALARM
  } bis_state_e;

  typedef struct packed {
    bis_state_e state;
    logic [15:0] timer;
    logic [7:0] ignLeft;
    logic [7:0] waitLeft;
    logic enable;
    logic pts;
    logic [31:0] time0;
    logic [31:0] time1;
    logic [31:0] time2;
    logic emergency_shutoff_valve;
    logic pilot;
    logic process;
    logic igniter;
    logic alarm;
  } bis_unit_s;

endpackage

// ### logic/bis_key_hold.sv
`timescale 1ns/1ps

// Fires one pulse once the key has been held through HOLD_TICKS full tick periods.
// The key must be released before it can fire again, so a stuck key starts only once.
module bis_key_hold #(
  parameter int HOLD_TICKS = bis_pkg::KEY_HOLD_TICKS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Time base and key
  input wire logic tick,
  input wire logic keyIn,
  // Result
  output logic holdDone
);
  import bis_pkg::*;

  if (HOLD_TICKS < 1 || HOLD_TICKS > 254) begin : g_bad_hold
    $error("bis_key_hold: HOLD_TICKS out of range");
  end

  typedef struct packed {
    logic [7:0] cnt;
    logic latched;
    logic fire;
  } bis_key_s;

  bis_key_s cur;
  bis_key_s nxt;

  // One extra tick is counted because the first tick may come just after the press.
  localparam logic [7:0] FIRE_AT = 8'(HOLD_TICKS + 1);

  always_comb begin
    nxt = cur;
    nxt.fire = 1'b0;
    if (!keyIn) begin
      nxt.cnt = 8'h00;
      nxt.latched = 1'b0;
    end else if (!cur.latched && tick) begin
      nxt.cnt = cur.cnt + 8'h01;
      if (nxt.cnt == FIRE_AT) begin
        nxt.fire = 1'b1;
        nxt.latched = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  assign holdDone = cur.fire;

endmodule // bis_key_hold

// ### logic/bis_sequencer.sv
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps

module bis_sequencer #(
  parameter int NUM_UNITS = 2,
  parameter int TICK_CYCLES = bis_pkg::TICK_CYCLES_DEF,
  parameter int HOLD_TICKS = bis_pkg::KEY_HOLD_TICKS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [bis_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Field inputs, one bit per unit
  input wire logic [NUM_UNITS-1:0] flameSense,
  input wire logic [NUM_UNITS-1:0] processDemand,
  input wire logic [NUM_UNITS-1:0] confirmKey,
  input wire logic [NUM_UNITS-1:0] stopKey,
  input wire logic [NUM_UNITS-1:0] shutdownReq,
  input wire logic [NUM_UNITS-1:0] alarmReq,
  // Field outputs, one bit per unit
  output logic [NUM_UNITS-1:0] esdValve,
  output logic [NUM_UNITS-1:0] pilotValve,
  output logic [NUM_UNITS-1:0] processValve,
  output logic [NUM_UNITS-1:0] igniterOn,
  output logic [NUM_UNITS-1:0] alarmOut
);
  import bis_pkg::*;

  // ---------------------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------------------
  if (NUM_UNITS < 1 || NUM_UNITS > 8) begin : g_bad_units
    $error("bis_sequencer: NUM_UNITS must be 1 to 8");
  end
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("bis_sequencer: TICK_CYCLES must be at least 2");
  end

  localparam int PW = $clog2(TICK_CYCLES);
  localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);

  typedef struct packed {
    bis_unit_s [NUM_UNITS-1:0] unit;
    logic [PW-1:0] pre;
    logic tick;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } bis_top_s;

  bis_top_s cur;
  bis_top_s nxt;
  logic [NUM_UNITS-1:0] keyFire;

  // ---------------------------------------------------------------------------
  // Confirm key hold detectors
  // ---------------------------------------------------------------------------
  for (genvar g = 0; g < NUM_UNITS; g++) begin : g_unit
    bis_key_hold #(
      .HOLD_TICKS(HOLD_TICKS)
    ) u_key (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .tick(cur.tick),
      .keyIn(confirmKey[g]),
      .holdDone(keyFire[g])
    );
    assign esdValve[g] = cur.unit[g].emergency_shutoff_valve;
    assign pilotValve[g] = cur.unit[g].pilot;
    assign processValve[g] = cur.unit[g].process;
    assign igniterOn[g] = cur.unit[g].igniter;
    assign alarmOut[g] = cur.unit[g].alarm;
  end

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic isAlarmClass(input bis_state_e s);
    return (s == ST_PILOT_FAIL) || (s == ST_SHUTDOWN) || (s == ST_ALARM);
  endfunction

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    bis_unit_s un;
    bis_state_e stNext;
    logic [15:0] dur;
    logic [2:0] aUnit;
    logic [4:0] aOff;
    logic addrOk;
    logic wrEn;
    logic clearReq;
    logic [31:0] rd;
    un = '0;
    stNext = ST_STOPPED;
    dur = 16'h0000;
    clearReq = 1'b0;
    rd = 32'h0000_0000;
    aUnit = paddr[UNIT_SHIFT +: 3];
    aOff = paddr[4:0];
    addrOk = (paddr[ADDR_W-1:UNIT_SHIFT+3] == '0) && (32'(aUnit) < NUM_UNITS) &&
             (aOff[1:0] == 2'b00) && (aOff <= OFF_STATUS);
    wrEn = psel && penable && cur.pready && pwrite && addrOk;
    nxt = cur;

    // Shared tick so every unit times in the same base.
    nxt.tick = 1'b0;
    if (cur.pre == PRE_LAST) begin
      nxt.pre = '0;
      nxt.tick = 1'b1;
    end else begin
      nxt.pre = cur.pre + PW'(1);
    end

    // The APB decode above answers unmapped offsets, units and unaligned addresses with an error.

    for (int u = 0; u < NUM_UNITS; u++) begin
      un = cur.unit[u];
      clearReq = 1'b0;

      // Register writes land at the access edge only.
      if (wrEn && (32'(aUnit) == u)) begin
        case (aOff)
          OFF_CTRL: begin
            if (pstrb[0]) begin
              un.enable = pwdata[CTRL_ENABLE_BIT];
              un.pts = pwdata[CTRL_PTS_BIT];
              clearReq = pwdata[CTRL_CLEAR_BIT];
            end
          end
          OFF_TIME0: un.time0 = mergeBytes(cur.unit[u].time0, pwdata, pstrb);
          OFF_TIME1: un.time1 = mergeBytes(cur.unit[u].time1, pwdata, pstrb);
          OFF_TIME2: un.time2 = mergeBytes(cur.unit[u].time2, pwdata, pstrb);
          default: begin
          end
        endcase
      end

      if (cur.tick && (un.timer != 16'hFFFF)) begin
        un.timer = un.timer + 16'h0001;
      end

      // Configured duration that ends the current state.
      case (cur.unit[u].state)
        ST_STARTUP: dur = STARTUP_TICKS;
        ST_FIRST_PURGE: dur = cur.unit[u].time0[T0_FIRST_PURGE_LSB +: 16];
        ST_IGNITE: dur = cur.unit[u].time0[T0_IGNITION_LSB +: 16];
        ST_PURGE: dur = cur.unit[u].time1[T1_PURGE_LSB +: 16];
        ST_WAIT: dur = cur.unit[u].time1[T1_WAIT_LSB +: 16];
        ST_FLAME_ESTABLISH: dur = cur.unit[u].time2[T2_ESTABLISH_LSB +: 16];
        default: dur = 16'hFFFF;
      endcase

      stNext = cur.unit[u].state;
      case (cur.unit[u].state)
        ST_DISABLED: begin
          if (cur.unit[u].enable) begin
            stNext = ST_STOPPED;
          end
        end
        ST_STOPPED: begin
          if (keyFire[u]) begin
            stNext = cur.unit[u].pts ? ST_IDLE : ST_STARTUP;
          end
        end
        ST_STARTUP: begin
          // The check is a settle period with every output off.
          if (cur.unit[u].timer >= dur) begin
            stNext = ST_FIRST_PURGE;
          end
        end
        ST_FIRST_PURGE: begin
          un.ignLeft = cur.unit[u].time2[T2_IGN_ATTEMPTS_LSB +: 8];
          if (cur.unit[u].timer >= dur) begin
            stNext = ST_IGNITE;
          end
        end
        ST_IGNITE: begin
          if (flameSense[u]) begin
            stNext = ST_FLAME_ESTABLISH;
          end else if (cur.unit[u].timer >= dur) begin
            stNext = ST_PURGE;
          end
        end
        ST_PURGE: begin
          if (cur.unit[u].ignLeft == 8'h00) begin
            stNext = ST_WAIT;
          end else if (cur.unit[u].timer >= dur) begin
            un.ignLeft = cur.unit[u].ignLeft - 8'h01;
            stNext = ST_IGNITE;
          end
        end
        ST_WAIT: begin
          if (cur.unit[u].waitLeft == 8'h00) begin
            stNext = ST_PILOT_FAIL;
          end else if (cur.unit[u].timer >= dur) begin
            un.waitLeft = cur.unit[u].waitLeft - 8'h01;
            stNext = ST_FIRST_PURGE;
          end
        end
        ST_FLAME_ESTABLISH: begin
          if (!flameSense[u]) begin
            un.ignLeft = cur.unit[u].time2[T2_IGN_ATTEMPTS_LSB +: 8];
            stNext = ST_IGNITE;
          end else if (cur.unit[u].timer >= dur) begin
            stNext = ST_PILOT_ON;
          end
        end
        ST_PILOT_ON: begin
          if (!flameSense[u]) begin
            un.ignLeft = cur.unit[u].time2[T2_IGN_ATTEMPTS_LSB +: 8];
            stNext = ST_IGNITE;
          end else if (processDemand[u]) begin
            stNext = ST_PROCESS_ONE_RUNNING;
          end
        end
        ST_IDLE: begin
          if (processDemand[u]) begin
            stNext = ST_STARTUP;
          end
        end
        ST_PROCESS_ONE_RUNNING: begin
          // Losing flame with the process valve open is treated like losing it at pilot on.
          if (!flameSense[u]) begin
            un.ignLeft = cur.unit[u].time2[T2_IGN_ATTEMPTS_LSB +: 8];
            stNext = ST_IGNITE;
          end else if (!processDemand[u]) begin
            stNext = cur.unit[u].pts ? ST_IDLE : ST_PILOT_ON;
          end
        end
        ST_PILOT_FAIL, ST_SHUTDOWN, ST_ALARM: begin
          if (clearReq && !alarmReq[u]) begin
            stNext = ST_STOPPED;
          end
        end
        default: stNext = ST_STOPPED;
      endcase

      // Overrides, lowest priority first.
      if (shutdownReq[u] && ((cur.unit[u].state == ST_PILOT_ON) || (cur.unit[u].state == ST_IDLE) ||
                             (cur.unit[u].state == ST_PROCESS_ONE_RUNNING))) begin
        stNext = ST_SHUTDOWN;
      end
      if (stopKey[u] && !isAlarmClass(cur.unit[u].state) && (cur.unit[u].state != ST_DISABLED)) begin
        stNext = ST_STOPPED;
      end
      if (alarmReq[u] && !isAlarmClass(cur.unit[u].state) && (cur.unit[u].state != ST_DISABLED)) begin
        stNext = ST_ALARM;
      end
      if (!un.enable) begin
        stNext = ST_DISABLED;
      end

      // Every start run gets a fresh set of wait retries.
      if ((stNext == ST_STARTUP) && (cur.unit[u].state != ST_STARTUP)) begin
        un.waitLeft = cur.unit[u].time2[T2_WAIT_ATTEMPTS_LSB +: 8];
      end
      if (stNext != cur.unit[u].state) begin
        un.timer = 16'h0000;
      end
      un.state = stNext;

      // Outputs follow the next state so they change in the same edge as the state.
      un.emergency_shutoff_valve = 1'b0;
      un.pilot = 1'b0;
      un.process = 1'b0;
      un.igniter = 1'b0;
      un.alarm = 1'b0;
      case (stNext)
        ST_DISABLED: begin
          un.igniter = 1'b0;
        end
        ST_STOPPED: begin
          un.alarm = 1'b1;
        end
        ST_IGNITE: begin
          un.emergency_shutoff_valve = 1'b1;
          un.pilot = 1'b1;
          un.igniter = 1'b1;
        end
        ST_FLAME_ESTABLISH, ST_PILOT_ON: begin
          un.emergency_shutoff_valve = 1'b1;
          un.pilot = 1'b1;
        end
        ST_PROCESS_ONE_RUNNING: begin
          un.emergency_shutoff_valve = 1'b1;
          un.pilot = 1'b1;
          un.process = 1'b1;
        end
        ST_PILOT_FAIL, ST_SHUTDOWN, ST_ALARM: begin
          un.alarm = 1'b1;
        end
        default: begin
          un.alarm = 1'b0;
        end
      endcase
      nxt.unit[u] = un;
    end

    // Read data is captured in the setup cycle and presented with pready in the access cycle.
    rd = 32'h0000_0000;
    for (int u = 0; u < NUM_UNITS; u++) begin
      if (32'(aUnit) == u) begin
        case (aOff)
          OFF_CTRL: begin
            rd[CTRL_ENABLE_BIT] = cur.unit[u].enable;
            rd[CTRL_PTS_BIT] = cur.unit[u].pts;
          end
          OFF_TIME0: rd = cur.unit[u].time0;
          OFF_TIME1: rd = cur.unit[u].time1;
          OFF_TIME2: rd = cur.unit[u].time2;
          OFF_STATUS: begin
            rd[ST_STATE_LSB +: 4] = cur.unit[u].state;
            rd[ST_ESD_BIT] = cur.unit[u].emergency_shutoff_valve;
            rd[ST_PILOT_BIT] = cur.unit[u].pilot;
            rd[ST_PROCESS_BIT] = cur.unit[u].process;
            rd[ST_IGNITER_BIT] = cur.unit[u].igniter;
            rd[ST_ALARM_BIT] = cur.unit[u].alarm;
            rd[ST_IGN_LEFT_LSB +: 8] = cur.unit[u].ignLeft;
            rd[ST_WAIT_LEFT_LSB +: 8] = cur.unit[u].waitLeft;
          end
          default: rd = 32'h0000_0000;
        endcase
      end
    end

    nxt.pready = 1'b0;
    nxt.pslverr = 1'b0;
    if (psel && !penable) begin
      nxt.pready = 1'b1;
      nxt.pslverr = !addrOk;
      nxt.prdata = (addrOk && !pwrite) ? rd : 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
      for (int u = 0; u < NUM_UNITS; u++) begin
        cur.unit[u].state <= ST_STOPPED;
        cur.unit[u].alarm <= 1'b1;
        cur.unit[u].enable <= CTRL_ENABLE_RST;
        cur.unit[u].pts <= CTRL_PTS_RST;
        cur.unit[u].time0 <= TIME0_RST;
        cur.unit[u].time1 <= TIME1_RST;
        cur.unit[u].time2 <= TIME2_RST;
      end
    end else begin
      cur <= nxt;
    end
  end

  assign prdata = cur.prdata;
  assign pready = cur.pready;
  assign pslverr = cur.pslverr;

endmodule // bis_sequencer

// ### dv/bis_seq_properties.sv
`timescale 1ns/1ps
module bis_seq_properties #(
  parameter int NUM_UNITS = 2
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // APB handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Field inputs
  input wire logic [NUM_UNITS-1:0] flameSense,
  input wire logic [NUM_UNITS-1:0] processDemand,
  input wire logic [NUM_UNITS-1:0] stopKey,
  input wire logic [NUM_UNITS-1:0] alarmReq,
  // Field outputs
  input wire logic [NUM_UNITS-1:0] esdValve,
  input wire logic [NUM_UNITS-1:0] pilotValve,
  input wire logic [NUM_UNITS-1:0] processValve,
  input wire logic [NUM_UNITS-1:0] igniterOn,
  input wire logic [NUM_UNITS-1:0] alarmOut
);
  // ----------------
  // Helpers
  // ----------------
  // Burning units that lose flame, and sparking units that see it.
  logic [NUM_UNITS-1:0] lost;
  logic [NUM_UNITS-1:0] lit;
  assign lost = pilotValve & ~igniterOn & ~flameSense & ~stopKey & ~alarmReq;
  assign lit = igniterOn & flameSense & ~stopKey & ~alarmReq;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  stop_closes_a: assert property (((esdValve | pilotValve | processValve | igniterOn) & $past(stopKey)) == '0)
    else $error("valve open after stop key");
  proc_needs_pilot_a: assert property ((processValve & ~(esdValve & pilotValve)) == '0)
    else $error("process valve without pilot");
  spark_valves_a: assert property ((igniterOn & ~(esdValve & pilotValve)) == '0)
    else $error("igniter without valves");
  alarm_closed_a: assert property ((alarmOut & (esdValve | pilotValve | processValve | igniterOn)) == '0)
    else $error("valve open with alarm");
  demand_valve_a: assert property ((processValve & ~$past(processDemand)) == '0)
    else $error("process valve without demand");
  flame_loss_a: assert property (|lost |=> (igniterOn & $past(lost)) == $past(lost))
    else $error("no reignite after flame loss");
  flame_seen_a: assert property (|lit |=> (pilotValve & ~igniterOn & $past(lit)) == $past(lit))
    else $error("spark continues with flame");
  apb_answer_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not one cycle after setup");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule // bis_seq_properties

bind bis_sequencer bis_seq_properties #(.NUM_UNITS(NUM_UNITS)) u_props (.core_clk, .rst_n, .psel, .penable,
  .pready, .pslverr, .flameSense, .processDemand, .stopKey, .alarmReq, .esdValve, .pilotValve, .processValve,
  .igniterOn, .alarmOut);

// ### dv/bis_field_model.sv
`timescale 1ns/1ps
// Flame detector beside the pilot: flame appears three cycles into sparking when fuel
// is usable, and lasts only while the pilot valve stays open and fuel stays usable.
module bis_field_model #(
  parameter int NUM_UNITS = 2
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Drive seen from the sequencer
  input wire logic [NUM_UNITS-1:0] pilotValve,
  input wire logic [NUM_UNITS-1:0] igniterOn,
  // Bench control
  input wire logic [NUM_UNITS-1:0] fuelOk,
  // Detector
  output logic [NUM_UNITS-1:0] flameSense
);
  logic [NUM_UNITS-1:0] spark1;
  logic [NUM_UNITS-1:0] spark2;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      spark1 <= '0;
      spark2 <= '0;
      flameSense <= '0;
    end else begin
      spark1 <= igniterOn & fuelOk;
      spark2 <= spark1;
      flameSense <= pilotValve & fuelOk & (flameSense | spark2);
    end
  end
endmodule // bis_field_model

// ### dv/tb_burner_ignition_sequencer.sv
`timescale 1ns/1ps
module tb_burner_ignition_sequencer;
  import bis_pkg::*;
  logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, rerr;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdq;
  logic [3:0] pstrb = 4'hf;
  logic [1:0] demand = 0, key = 0, stopK = 0, sdReq = 0, alReq = 0, fuelOk = 2'b11;
  logic [1:0] flame, emergency_shutoff_valve, pil, prc, ign, alm;
  logic [31:0] rv[3] = '{TIME0_RST, TIME1_RST, TIME2_RST};
  int bad_count = 0, checked = 0, cyc = 0, sparks = 0;
  int badAddr[4] = '{256, 64, 20, 2};
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if ($rose(ign[0])) sparks++;
    if (cyc == 60000) begin
      bad_count++;
      wrap_up();
    end
  end
  bis_sequencer #(.TICK_CYCLES(4), .HOLD_TICKS(3)) u_dut (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .flameSense(flame), .processDemand(demand), .confirmKey(key),
    .stopKey(stopK), .shutdownReq(sdReq), .alarmReq(alReq), .esdValve(emergency_shutoff_valve), .pilotValve(pil),
    .processValve(prc), .igniterOn(ign), .alarmOut(alm));
  bis_field_model u_field (.core_clk, .rst_n, .pilotValve(pil), .igniterOn(ign), .fuelOk, .flameSense(flame));
  // ----------------
  // Tasks
  // ----------------
  task automatic apb(input logic wr, input int a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1;
    pwrite <= wr;
    paddr <= 12'(a);
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    // Registered answers are looked at on the falling edge, settled for the rising edge that takes them.
    do begin
      @(negedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      wrap_up();
    end
    rdq = prdata;
    rerr = pslverr;
    @(posedge core_clk);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Polling may miss short states, so only lasting states are awaited.
  task automatic waitSt(input int u, input bis_state_e s);
    int n;
    n = 0;
    do begin
      apb(0, u * 32 + 16, 0);
      n++;
    end while (rdq[3:0] !== s && n < 400);
    chk("state", 32'(s), {28'h0, rdq[3:0]});
  endtask
  task automatic press(input int u, input int len);
    @(posedge core_clk);
    key[u] <= 1;
    repeat (len) @(posedge core_clk);
    key[u] <= 0;
  endtask
  task automatic wrap_up;
    $display("checked %0d, bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------
  // Tests
  // ----------------
  initial begin
    void'($urandom(32'h5c20));
    repeat (3) @(posedge core_clk);
    rst_n <= 1;
    chk("alarm", 2'b11, alm);
    for (int u = 0; u < 2; u++) begin
      apb(0, u * 32, 0);
      chk("ctrl", 1, rdq);
      for (int r = 0; r < 3; r++) begin
        apb(0, u * 32 + 4 * r + 4, 0);
        chk("time", rv[r], rdq);
      end
      apb(0, u * 32 + 16, 0);
      chk("status", 32'h101, {23'h0, rdq[8:0]});
    end
    foreach (badAddr[i]) begin
      apb(0, badAddr[i], 0);
      chk("error", 1, rerr);
    end
    $display("test reset done");
    for (int u = 0; u < 2; u++) begin
      apb(1, u * 32 + 4, {16'd6, 16'($urandom_range(2, 5))});
      apb(1, u * 32 + 8, 32'h0003_0002);
      apb(1, u * 32 + 12, 32'h0102_0004);
    end
    apb(0, 12, 0);
    chk("time2", 32'h0102_0004, rdq);
    pstrb <= 4'h1;
    apb(1, 40, 32'hAAAA_AA07);
    pstrb <= 4'hf;
    apb(0, 40, 0);
    chk("strobe", 32'h0003_0007, rdq);
    press(0, 8);
    waitSt(0, ST_STOPPED);
    press(0, 40 + $urandom_range(0, 8));
    waitSt(0, ST_PILOT_ON);
    chk("ign left", 2, rdq[23:16]);
    waitSt(1, ST_STOPPED);
    demand[0] <= 1;
    waitSt(0, ST_PROCESS_ONE_RUNNING);
    chk("process", 1, prc[0]);
    demand[0] <= 0;
    waitSt(0, ST_PILOT_ON);
    fuelOk[0] <= 0;
    waitSt(0, ST_IGNITE);
    chk("ign left", 2, rdq[23:16]);
    fuelOk[0] <= 1;
    waitSt(0, ST_PILOT_ON);
    stopK[0] <= 1;
    @(posedge core_clk);
    stopK[0] <= 0;
    waitSt(0, ST_STOPPED);
    $display("test run done");
    fuelOk[0] <= 0;
    sparks = 0;
    press(0, 40);
    waitSt(0, ST_PILOT_FAIL);
    chk("sparks", 6, sparks);
    chk("alarm", 1, alm[0]);
    apb(1, 0, 5);
    waitSt(0, ST_STOPPED);
    fuelOk[0] <= 1;
    $display("test failure done");
    apb(1, 32, 3);
    press(1, 40);
    waitSt(1, ST_IDLE);
    chk("valves", 0, {emergency_shutoff_valve[1], pil[1], ign[1]});
    demand[1] <= 1;
    waitSt(1, ST_PROCESS_ONE_RUNNING);
    demand[1] <= 0;
    waitSt(1, ST_IDLE);
    sdReq[1] <= 1;
    waitSt(1, ST_SHUTDOWN);
    sdReq[1] <= 0;
    apb(1, 32, 7);
    waitSt(1, ST_STOPPED);
    alReq[0] <= 1;
    waitSt(0, ST_ALARM);
    apb(1, 0, 5);
    waitSt(0, ST_ALARM);
    alReq[0] <= 0;
    apb(1, 0, 5);
    waitSt(0, ST_STOPPED);
    apb(1, 32, 0);
    waitSt(1, ST_DISABLED);
    chk("disabled", 0, {alm[1], emergency_shutoff_valve[1], pil[1], ign[1]});
    apb(1, 32, 1);
    waitSt(1, ST_STOPPED);
    $display("test demand done");
    wrap_up();
  end
endmodule // tb_burner_ignition_sequencer
